// [mst_consts.svh]
// constants for the skip, table-read and exclusive-or execution block
`ifndef MST_CONSTS_SVH
`define MST_CONSTS_SVH

`define MST_OP_W 4
`define MST_PC_W 12
`define MST_PC_STEP 12'h001
`define MST_LAST_PAGE 4'hf
`define MST_PAGE_W 4
`define MST_ROM_W 15
`define MST_ROM_HI_W 7
`define MST_NIB_HI 7:4
`define MST_NIB_LO 3:0
`define MST_ZERO_BYTE 8'h00
`define MST_ACC_RST 8'h00
`define MST_PC_RST 12'h000
`define MST_TBL_HIGH_RST 7'h00
`define MST_Z_RST 1'b0
`define MST_ROM_LO 7:0
`define MST_ROM_HI `MST_ROM_W-1:`MST_ROM_W-`MST_ROM_HI_W
`define MST_PAGE_BITS `MST_PC_W-1:`MST_PC_W-`MST_PAGE_W

`endif

// [mst_pkg.sv]
// types shared by the skip, table-read and exclusive-or execution block
`default_nettype none
package mst_pkg;
    // opcodes of the instruction group handled here
    typedef enum logic [3:0] {
        MST_NOP,
        MST_SWAP_NIB_ACC,
        MST_SKZ,
        MST_SKZA,
        MST_SKZB,
        MST_TRDC,
        MST_TRDL,
        MST_XOR_AM,
        MST_XOR_MA,
        MST_XOR_AI
    } mst_op_t;

    // execution stage state
    typedef enum logic {
        MST_RUN,
        MST_DUMMY
    } mst_state_t;
endpackage : mst_pkg
`default_nettype wire

// [mst_exec.sv]
// execution unit for nibble swap, zero skips, table reads and xor forms
`timescale 1ns/10ps
`default_nettype none
`include "mst_consts.svh"

module mst_exec
    import mst_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire mst_op_t op_code,
    input wire logic [7:0] mem_rd_data,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] imm_data,
    input wire logic [7:0] tbl_ptr,
    input wire logic [`MST_ROM_W-1:0] rom_data,
    output logic [`MST_PC_W-1:0] rom_addr,
    output logic [`MST_PC_W-1:0] pc,
    output logic [7:0] acc,
    output logic [`MST_ROM_HI_W-1:0] tbl_high,
    output logic zero_flag,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_en,
    output logic op_ready,
    output logic squash
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mst_state_t state_ff, nxt_state;
    logic [`MST_PC_W-1:0] pc_ff, nxt_pc;
    logic [7:0] acc_ff, nxt_acc;
    logic [`MST_ROM_HI_W-1:0] tbl_high_ff, nxt_tbl_high;
    logic z_ff, nxt_z;
    logic [7:0] wr_data_ff, nxt_wr_data;
    logic wr_en_ff, nxt_wr_en;
    logic skip_take;
    logic [7:0] xor_res;

    // table address: page bits from pc or forced to last page
    assign rom_addr = (op_code == MST_TRDL)
        ? {`MST_LAST_PAGE, tbl_ptr}
        : {pc_ff[`MST_PC_W-1 -: `MST_PAGE_W], tbl_ptr};
    assign xor_res = acc_ff ^ ((op_code == MST_XOR_AI) ? imm_data
                                                       : mem_rd_data);
    // no new op accepted while the dummy cycle runs
    assign op_ready = (state_ff == MST_RUN);
    assign squash = (state_ff == MST_DUMMY);
    assign pc = pc_ff;
    assign acc = acc_ff;
    assign tbl_high = tbl_high_ff;
    assign zero_flag = z_ff;
    assign mem_wr_data = wr_data_ff;
    assign mem_wr_en = wr_en_ff;

    // ------------------------------------------------------------
    // next-state and datapath
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = MST_RUN;
        nxt_pc = pc_ff;
        nxt_acc = acc_ff;
        nxt_tbl_high = tbl_high_ff;
        nxt_z = z_ff;
        nxt_wr_data = wr_data_ff;
        nxt_wr_en = 1'b0;
        skip_take = 1'b0;
        if (state_ff == MST_DUMMY) begin
            // dummy cycle: fetch after the skipped word
            nxt_pc = pc_ff + `MST_PC_STEP;
        end else if (op_valid) begin
            nxt_pc = pc_ff + `MST_PC_STEP;
            case (op_code)
                MST_SWAP_NIB_ACC: begin
                    nxt_acc = {mem_rd_data[`MST_NIB_LO],
                               mem_rd_data[`MST_NIB_HI]};
                end
                MST_SKZ: begin
                    skip_take = (mem_rd_data == `MST_ZERO_BYTE);
                end
                MST_SKZA: begin
                    nxt_acc = mem_rd_data;
                    skip_take = (mem_rd_data == `MST_ZERO_BYTE);
                end
                MST_SKZB: begin
                    skip_take = ~mem_rd_data[bit_sel];
                end
                MST_TRDC, MST_TRDL: begin
                    // flags untouched by table reads
                    nxt_wr_data = rom_data[`MST_ROM_LO];
                    nxt_wr_en = 1'b1;
                    nxt_tbl_high = rom_data[`MST_ROM_HI];
                end
                MST_XOR_AM, MST_XOR_AI: begin
                    nxt_acc = xor_res;
                    nxt_z = (xor_res == `MST_ZERO_BYTE);
                end
                MST_XOR_MA: begin
                    nxt_wr_data = xor_res;
                    nxt_wr_en = 1'b1;
                    nxt_z = (xor_res == `MST_ZERO_BYTE);
                end
                default: begin
                    nxt_acc = acc_ff;
                end
            endcase
            if (skip_take) begin
                nxt_state = MST_DUMMY;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= MST_RUN;
            pc_ff <= `MST_PC_RST;
            acc_ff <= `MST_ACC_RST;
            tbl_high_ff <= `MST_TBL_HIGH_RST;
            z_ff <= `MST_Z_RST;
            wr_data_ff <= `MST_ZERO_BYTE;
            wr_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            tbl_high_ff <= nxt_tbl_high;
            z_ff <= nxt_z;
            wr_data_ff <= nxt_wr_data;
            wr_en_ff <= nxt_wr_en;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // one-cycle results of each accepted op; flags other than zero are
    // not modelled, so only zero and the data paths are watched
    AST_SWAP: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_SWAP_NIB_ACC |=>
        acc == {$past(mem_rd_data[`MST_NIB_LO]),
                $past(mem_rd_data[`MST_NIB_HI])}
        && $stable(zero_flag) && !mem_wr_en)
        else $error("swap result wrong");

    AST_SKZ: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_SKZ
        && mem_rd_data == `MST_ZERO_BYTE
        |=> squash ##1 !squash)
        else $error("zero skip not two cycles");

    AST_NOSKIP: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_SKZ
        && mem_rd_data != `MST_ZERO_BYTE
        |=> !squash && $stable(zero_flag))
        else $error("skip taken on nonzero");

    // a squash never stretches past the single dummy cycle
    AST_DUMMY1: assert property (@(posedge clk) disable iff (sys_rst)
        squash |=> !squash)
        else $error("dummy cycle longer than one");

    AST_SKZA: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_SKZA |=>
        acc == $past(mem_rd_data) && squash == (acc == `MST_ZERO_BYTE)
        && $stable(zero_flag))
        else $error("copy skip wrong");

    AST_SKZB: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_SKZB |=>
        squash == !$past(mem_rd_data[bit_sel])
        && $stable(zero_flag) && $stable(acc))
        else $error("bit skip wrong");

    // skips leave data memory alone whichever way they go
    AST_SKNOWR: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid
        && (op_code == MST_SKZ || op_code == MST_SKZA || op_code == MST_SKZB)
        |=> !mem_wr_en)
        else $error("skip wrote data memory");

    AST_TRDC: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_TRDC |=>
        mem_wr_en && mem_wr_data == $past(rom_data[`MST_ROM_LO])
        && tbl_high == $past(rom_data[`MST_ROM_HI]) && $stable(zero_flag)
        && $past(rom_addr[`MST_PAGE_BITS]) == $past(pc[`MST_PAGE_BITS]))
        else $error("table read wrong");

    AST_TRDL: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_TRDL |=>
        mem_wr_en && mem_wr_data == $past(rom_data[`MST_ROM_LO])
        && tbl_high == $past(rom_data[`MST_ROM_HI]) && $stable(zero_flag)
        && $past(rom_addr[`MST_PAGE_BITS]) == `MST_LAST_PAGE)
        else $error("last page table read wrong");

    AST_XAM: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_XOR_AM |=>
        acc == ($past(acc) ^ $past(mem_rd_data))
        && zero_flag == (acc == `MST_ZERO_BYTE) && !mem_wr_en)
        else $error("xor acc wrong");

    AST_XMA: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_XOR_MA |=>
        mem_wr_en && mem_wr_data == ($past(acc) ^ $past(mem_rd_data))
        && zero_flag == (mem_wr_data == `MST_ZERO_BYTE) && $stable(acc))
        else $error("xor mem wrong");

    AST_XAI: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid && op_code == MST_XOR_AI |=>
        acc == ($past(acc) ^ $past(imm_data))
        && zero_flag == (acc == `MST_ZERO_BYTE))
        else $error("xor imm wrong");

    AST_PC: assert property (@(posedge clk) disable iff (sys_rst)
        squash |=> pc == $past(pc) + `MST_PC_STEP)
        else $error("pc not advanced past skipped word");

    // an op offered during the dummy cycle must be dropped entirely,
    // otherwise the skipped word would still execute
    AST_REFUSE: assert property (@(posedge clk) disable iff (sys_rst)
        squash && op_valid |=> $stable(acc) && $stable(zero_flag)
        && $stable(tbl_high) && !mem_wr_en)
        else $error("op taken during dummy cycle");

    AST_PCSTEP: assert property (@(posedge clk) disable iff (sys_rst)
        op_ready && op_valid |=> pc == $past(pc) + `MST_PC_STEP)
        else $error("pc not advanced by one op");

endmodule : mst_exec
`default_nettype wire

// [mst_exec_test.sv]
// self-checking bench for the skip, table-read and xor execution unit
`timescale 1ns/10ps
`default_nettype none
`include "mst_consts.svh"
module mst_exec_test
    import mst_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    mst_op_t op_code = MST_NOP;
    logic [7:0] mem_rd_data = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] imm_data = 8'h00;
    logic [7:0] tbl_ptr = 8'h00;
    logic [`MST_ROM_W-1:0] rom_data;
    logic [`MST_PC_W-1:0] rom_addr;
    logic [`MST_PC_W-1:0] pc;
    logic [7:0] acc;
    logic [`MST_ROM_HI_W-1:0] tbl_high;
    logic zero_flag;
    logic [7:0] mem_wr_data;
    logic mem_wr_en;
    logic op_ready;
    logic squash;
    int errors = 0;
    int compares = 0;
    logic [`MST_PC_W-1:0] epc = `MST_PC_RST;
    logic [`MST_ROM_W-1:0] ew;
    // ---------------------------------------------------------------
    // program memory: word differs from address so a wrong page shows
    // ---------------------------------------------------------------
    function automatic logic [14:0] rom_of(input logic [11:0] a);
        return {a[11:5], a[7:0] ^ 8'ha5};
    endfunction : rom_of
    assign rom_data = rom_of(rom_addr);
    mst_exec i_mst_exec (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .mem_rd_data(mem_rd_data), .bit_sel(bit_sel),
        .imm_data(imm_data), .tbl_ptr(tbl_ptr), .rom_data(rom_data),
        .rom_addr(rom_addr), .pc(pc), .acc(acc), .tbl_high(tbl_high),
        .zero_flag(zero_flag), .mem_wr_data(mem_wr_data),
        .mem_wr_en(mem_wr_en), .op_ready(op_ready), .squash(squash));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [14:0] e,
        input logic [14:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // one instruction; a taken skip also offers a bogus op in the dummy
    task automatic op(input mst_op_t c, input logic [7:0] m,
        input logic [2:0] b, input logic [7:0] x, input logic [7:0] p,
        input logic sk);
        logic [11:0] ea;
        ea = (c == MST_TRDL) ? {`MST_LAST_PAGE, p} : {epc[11:8], p};
        op_valid = 1'b1;
        op_code = c;
        mem_rd_data = m;
        bit_sel = b;
        imm_data = x;
        tbl_ptr = p;
        #1 chk("rom_addr", ea, rom_addr);
        @(negedge clk);
        epc = epc + `MST_PC_STEP;
        chk("squash", sk, squash);
        chk("op_ready", !sk, op_ready);
        chk("pc", epc, pc);
        if (sk) begin
            op_code = MST_XOR_AI;
            imm_data = 8'hff;
            @(negedge clk);
            epc = epc + `MST_PC_STEP;
            chk("squash_end", 1'b0, squash);
            chk("pc_skip", epc, pc);
        end
    endtask : op
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_xor();
        op(MST_XOR_AI, 8'h00, 3'h0, 8'h3c, 8'h00, 1'b0);
        chk("acc", 8'h3c, acc);
        chk("zf", 1'b0, zero_flag);
        op(MST_XOR_AI, 8'h00, 3'h0, 8'h3c, 8'h00, 1'b0);
        chk("zf", 1'b1, zero_flag);
        op(MST_XOR_AM, 8'h5a, 3'h0, 8'hff, 8'h00, 1'b0);
        chk("acc", 8'h5a, acc);
        chk("zf", 1'b0, zero_flag);
        op(MST_XOR_MA, 8'hff, 3'h0, 8'hff, 8'h00, 1'b0);
        chk("wr", 9'h1a5, {mem_wr_en, mem_wr_data});
        op(MST_XOR_MA, 8'h5a, 3'h0, 8'hff, 8'h00, 1'b0);
        chk("wr", 9'h100, {mem_wr_en, mem_wr_data});
        chk("acc_zf", 9'h0b5, {acc, zero_flag});
        op(MST_NOP, 8'h00, 3'h0, 8'h00, 8'h00, 1'b0);
        chk("wr_en", 1'b0, mem_wr_en);
    endtask : t_xor
    task automatic t_swap();
        op(MST_SWAP_NIB_ACC, 8'h3c, 3'h0, 8'h00, 8'h00, 1'b0);
        chk("swap", 10'h30e, {acc, zero_flag, mem_wr_en});
    endtask : t_swap
    task automatic t_skip();
        op(MST_SKZ, 8'h00, 3'h0, 8'h00, 8'h00, 1'b1);
        chk("acc", 8'hc3, acc);
        op(MST_SKZ, 8'h01, 3'h0, 8'h00, 8'h00, 1'b0);
        op(MST_SKZA, 8'h00, 3'h0, 8'h00, 8'h00, 1'b1);
        chk("acc", 8'h00, acc);
        op(MST_SKZA, 8'h7e, 3'h0, 8'h00, 8'h00, 1'b0);
        chk("acc", 8'h7e, acc);
        op(MST_SKZB, 8'hf7, 3'h3, 8'h00, 8'h00, 1'b1);
        op(MST_SKZB, 8'h08, 3'h3, 8'h00, 8'h00, 1'b0);
        chk("acc_zf", 9'h0fd, {acc, zero_flag});
    endtask : t_skip
    task automatic t_table();
        ew = rom_of({epc[11:8], 8'h34});
        op(MST_TRDC, 8'h00, 3'h0, 8'h00, 8'h34, 1'b0);
        chk("tbl", ew, {tbl_high, mem_wr_data});
        chk("wr_en", 1'b1, mem_wr_en);
        ew = rom_of({`MST_LAST_PAGE, 8'h9c});
        op(MST_TRDL, 8'h00, 3'h0, 8'h00, 8'h9c, 1'b0);
        chk("tbl", ew, {tbl_high, mem_wr_data});
        chk("zf", 1'b1, zero_flag);
    endtask : t_table
    // main sequence, inputs changing on falling edges only
    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        chk("rst_pc", `MST_PC_RST, pc);
        chk("rst_acc", `MST_ACC_RST, acc);
        chk("rst_st", 4'h8, {op_ready, squash, zero_flag, mem_wr_en});
        t_xor();
        t_swap();
        t_skip();
        t_table();
        op_valid = 1'b0;
        @(negedge clk);
        test_done();
    end
    // a hang counts as a mismatch
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule : mst_exec_test
`default_nettype wire
